// ===== verilog/gpio_edge_irq_eoi_nesting.sv
// end-of-interrupt nesting logic with an eight-line edge interrupt port
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
module gpio_edge_irq_eoi_nesting
  import eoi_gpio_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic resetn_i,
  // register port
  input wire logic [eoi_gpio_pkg::ADDR_W-1:0] reg_addr_i,
  input wire logic [eoi_gpio_pkg::DATA_W-1:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [eoi_gpio_pkg::DATA_W-1:0] reg_rdata_o,
  // links to the enable, mask and vector registers outside
  input wire logic [eoi_gpio_pkg::CHAN_N-1:0] chan_enable_i,
  input wire logic [eoi_gpio_pkg::CHAN_N-1:0] chan_mask_i,
  input wire logic [3:0] vector_base_i,
  input wire logic eoi_mode_i,
  // events of every channel, line channels included, one-cycle pulses
  input wire logic [eoi_gpio_pkg::CHAN_N-1:0] chan_event_i,
  // polled service clears pending bits, one-cycle pulses
  input wire logic [eoi_gpio_pkg::CHAN_N-1:0] pend_clear_i,
  // service completion per channel, one-cycle pulses
  input wire logic [eoi_gpio_pkg::CHAN_N-1:0] service_done_i,
  // acknowledge cycle request and answer
  input wire logic iack_i,
  output logic [7:0] vector_o,
  output logic vector_valid_o,
  output logic irq_o,
  // general purpose lines
  input wire logic [eoi_gpio_pkg::LINE_W-1:0] gp_line_i,
  output logic [eoi_gpio_pkg::LINE_W-1:0] gp_line_o,
  output logic [eoi_gpio_pkg::LINE_W-1:0] gp_line_oe_o
);
  import eoi_gpio_pkg::*;

  // all registered state of the block outside the line synchroniser
  typedef struct packed {
    logic [LINE_W-1:0] port_data; // output levels
    logic [LINE_W-1:0] edge_pol; // edge select per line
    logic [LINE_W-1:0] direction; // one means output
    logic [CHAN_N-1:0] in_svc; // in-service bits, b low, a high
    logic [CHAN_N-1:0] pend; // pending bits
    logic [LINE_W-1:0] det_prev; // last detector output
    logic [7:0] vector; // vector handed out
    logic vector_valid; // answer strobe
    logic [DATA_W-1:0] rdata; // read data, one cycle late
  } core_state_t;

  core_state_t st; // registered state
  core_state_t next_st; // next state
  logic [LINE_W-1:0] line_in; // synchronised line levels
  logic [LINE_W-1:0] det_now; // detector output this cycle
  logic [CHAN_N-1:0] line_evt; // line events on channel slots
  logic [CHAN_N-1:0] evt_set; // all events that set pending
  logic [CHAN_N-1:0] allowed; // channels not blocked by in-service
  logic [CHAN_N-1:0] eligible; // channels that may request
  logic [3:0] top_code; // highest eligible channel
  logic any_eligible; // some channel may request
  logic [3:0] svc_top; // highest in-service channel
  logic svc_any; // some in-service bit set

  // line synchroniser
  // asynchronous lines pass two flops before the detector sees them
  line_sync #(
    .WIDTH(LINE_W)
  ) u_line_sync (
    .core_clk_i(core_clk_i),
    .resetn_i(resetn_i),
    .async_i(gp_line_i),
    .sync_o(line_in)
  );

  // transition detector
  // xor output falls on the selected edge; an edge bit rewrite
  // can also make it fall, so program it before enabling
  always_comb begin
    det_now = line_in ^ st.edge_pol;
    line_evt = '0;
    for (int i = 0; i < LINE_W; i++) begin
      // each line lands on its own channel
      line_evt[LINE_CHAN_MAP[i*4 +: 4]] = st.det_prev[i] & ~det_now[i];
    end
  end

  // only enabled channels record events
  assign evt_set = (line_evt | chan_event_i) & chan_enable_i;

  // nesting gate and priority encoder
  // an in-service bit blocks its own channel and all below it
  always_comb begin
    logic blk;
    logic [CHAN_N-1:0] svc_eff;
    blk = 1'b0;
    // stale in-service bits must not block once the mode drops
    svc_eff = eoi_mode_i ? st.in_svc : '0;
    allowed = '0;
    svc_top = 4'h0;
    svc_any = 1'b0;
    for (int i = CHAN_N - 1; i >= 0; i--) begin
      if (svc_eff[i] && !blk) begin
        svc_top = 4'(i);
        svc_any = 1'b1;
      end
      blk = blk | svc_eff[i];
      allowed[i] = ~blk;
    end
    eligible = st.pend & chan_enable_i & chan_mask_i & allowed;
    top_code = 4'h0;
    any_eligible = 1'b0;
    for (int i = 0; i < CHAN_N; i++) begin
      // later, higher index wins
      if (eligible[i]) begin
        top_code = 4'(i);
        any_eligible = 1'b1;
      end
    end
  end

  // request line, also while a handler runs in automatic mode
  assign irq_o = any_eligible;

  // next-state logic: registers, acknowledge and in-service
  always_comb begin
    logic [DATA_W-1:0] rd;
    rd = '0;
    next_st = st;
    next_st.det_prev = det_now;
    next_st.vector_valid = 1'b0;
    // register writes
    if (reg_wr_i) begin
      case (reg_addr_i)
        OFS_PORT_DATA: next_st.port_data = reg_wdata_i;
        OFS_EDGE_POL: next_st.edge_pol = reg_wdata_i;
        OFS_DIRECTION: next_st.direction = reg_wdata_i;
        // zero bits clear, one bits keep
        OFS_IN_SVC_A: next_st.in_svc[15:8] = st.in_svc[15:8] & reg_wdata_i;
        OFS_IN_SVC_B: next_st.in_svc[7:0] = st.in_svc[7:0] & reg_wdata_i;
        default: begin
          // other offsets take no write
        end
      endcase
    end
    next_st.in_svc = next_st.in_svc & ~service_done_i;
    // pending: polled clears and disabled channels drop first
    next_st.pend = st.pend & ~pend_clear_i & chan_enable_i;
    // an acknowledge acts only when some channel is eligible
    if (iack_i && any_eligible) begin
      next_st.vector = {vector_base_i, top_code};
      next_st.vector_valid = 1'b1;
      // handing the vector clears that pending bit
      next_st.pend[top_code] = 1'b0;
      // software mode marks the channel in service
      if (eoi_mode_i) begin
        next_st.in_svc[top_code] = 1'b1;
      end
    end
    // events still set pending; set beats every clear
    next_st.pend = next_st.pend | evt_set;
    // automatic mode keeps no in-service history
    if (!eoi_mode_i) begin
      next_st.in_svc = '0;
    end
    if (reg_rd_i) begin
      case (reg_addr_i)
        OFS_PORT_DATA: begin
          rd = (st.port_data & st.direction) | (line_in & ~st.direction);
        end
        OFS_EDGE_POL: rd = st.edge_pol;
        OFS_DIRECTION: rd = st.direction;
        OFS_IN_SVC_A: rd = st.in_svc[15:8];
        OFS_IN_SVC_B: rd = st.in_svc[7:0];
        OFS_PEND_A: rd = st.pend[15:8];
        OFS_PEND_B: rd = st.pend[7:0];
        default: rd = '0; // unmapped reads return zero
      endcase
    end
    next_st.rdata = rd;
  end

  // state register, synchronous active-low reset
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st.port_data <= RST_PORT_DATA;
      st.edge_pol <= RST_EDGE_POL;
      st.direction <= RST_DIRECTION;
      st.in_svc <= RST_IN_SVC;
      st.pend <= RST_PEND;
      st.det_prev <= '0;
      st.vector <= '0;
      st.vector_valid <= 1'b0;
      st.rdata <= '0;
    end else begin
      st <= next_st;
    end
  end

  // per-line drivers
  // enable follows direction, so input lines stay undriven
  assign gp_line_o = st.port_data;
  assign gp_line_oe_o = st.direction;
  assign vector_o = st.vector;
  assign vector_valid_o = st.vector_valid;
  assign reg_rdata_o = st.rdata;

  // checks on the block's own outputs and state
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  chk_auto_isr_low: assert property (
    !eoi_mode_i |=> st.in_svc == 16'h0000)
    else $error("in-service bit set in automatic mode");

  chk_auto_request: assert property (
    (!eoi_mode_i && (st.pend & chan_enable_i & chan_mask_i) != 16'h0000)
      |-> irq_o)
    else $error("automatic mode request missing");

  chk_ack_pend_clr: assert property (
    vector_valid_o |-> !st.pend[vector_o[3:0]] ||
      ((($past(evt_set) >> vector_o[3:0]) & 16'h0001) != 16'h0000))
    else $error("pending bit kept after acknowledge");

  chk_soft_isr_set: assert property (
    (iack_i && any_eligible && eoi_mode_i && service_done_i == 16'h0000)
      ##1 eoi_mode_i |-> st.in_svc[vector_o[3:0]])
    else $error("in-service bit not set on acknowledge");

  chk_nest_priority: assert property (
    (iack_i && svc_any) |=> !vector_valid_o ||
      (vector_o[3:0] > $past(svc_top)))
    else $error("vector at or below in-service level");

  chk_no_sw_set: assert property (
    !iack_i |=> (st.in_svc & ~$past(st.in_svc)) == 16'h0000)
    else $error("in-service bit set without acknowledge");

  chk_vector_form: assert property (
    (iack_i && any_eligible) |=> vector_valid_o &&
      vector_o == {$past(vector_base_i), $past(top_code)})
    else $error("vector not formed from base and code");

  chk_data_read: assert property (
    (reg_rd_i && reg_addr_i == OFS_PORT_DATA) |=> reg_rdata_o ==
      (($past(st.port_data) & $past(st.direction)) |
       ($past(line_in) & ~$past(st.direction))))
    else $error("port data read mismatch");

  chk_data_drive: assert property (
    (reg_wr_i && reg_addr_i == OFS_PORT_DATA) |=>
      gp_line_o == $past(reg_wdata_i) && gp_line_oe_o == $past(st.direction))
    else $error("output lines do not follow data write");

  chk_line_edge: assert property (
    ((line_evt & chan_enable_i) != 16'h0000) |=>
      (st.pend & $past(line_evt & chan_enable_i)) ==
      $past(line_evt & chan_enable_i))
    else $error("line edge did not set pending");

  cov_nested_ack: cover property (
    svc_any && iack_i && any_eligible);
  cov_isr_write: cover property (
    reg_wr_i && reg_addr_i == OFS_IN_SVC_A && st.in_svc[15:8] != 8'h00);
  cov_line_irq: cover property (
    line_evt != 16'h0000 ##1 irq_o);
endmodule : gpio_edge_irq_eoi_nesting

// ===== verilog/eoi_gpio_pkg.sv
// shared constants for the end-of-interrupt nesting and line port block
package eoi_gpio_pkg;
  // widths
  localparam int LINE_W = 8;
  localparam int CHAN_N = 16;
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  // register offsets on the plain register port
  localparam logic [2:0] OFS_PORT_DATA = 3'h0;
  localparam logic [2:0] OFS_EDGE_POL = 3'h1;
  localparam logic [2:0] OFS_DIRECTION = 3'h2;
  localparam logic [2:0] OFS_IN_SVC_A = 3'h3;
  localparam logic [2:0] OFS_IN_SVC_B = 3'h4;
  localparam logic [2:0] OFS_PEND_A = 3'h5;
  localparam logic [2:0] OFS_PEND_B = 3'h6;
  // reset values
  localparam logic [7:0] RST_PORT_DATA = 8'h00;
  localparam logic [7:0] RST_EDGE_POL = 8'h00;
  localparam logic [7:0] RST_DIRECTION = 8'h00;
  localparam logic [15:0] RST_IN_SVC = 16'h0000;
  localparam logic [15:0] RST_PEND = 16'h0000;
  // channel code of each line, four bits per line, line 0 lowest
  localparam logic [31:0] LINE_CHAN_MAP = 32'hFE763210;
  // synchroniser depth for line inputs
  localparam int SYNC_STAGES = 2;
endpackage : eoi_gpio_pkg

// ===== verilog/line_sync.sv
// two-stage synchroniser for the general purpose line inputs
`timescale 1ns/1ps
module line_sync #(
  parameter int WIDTH = 8
) (
  input wire logic core_clk_i,
  input wire logic resetn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  // both stages held in one record
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;

  sync_state_t st; // registered state
  sync_state_t next_st; // next state

  // first stage feeds only the second stage
  always_comb begin
    next_st = st;
    next_st.meta = async_i;
    next_st.stable = st.meta;
  end

  // synchronous active-low reset, constants only
  always_ff @(posedge core_clk_i) begin
    if (!resetn_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign sync_o = st.stable;
endmodule : line_sync

// ===== bench/cpu_model.sv
// processor core model: register accesses and acknowledge cycles
`timescale 1ns/1ps
module cpu_model
  import eoi_gpio_pkg::*;
(
  input wire logic core_clk_i,
  output logic [eoi_gpio_pkg::ADDR_W-1:0] reg_addr_o,
  output logic [eoi_gpio_pkg::DATA_W-1:0] reg_wdata_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  input wire logic [eoi_gpio_pkg::DATA_W-1:0] reg_rdata_i,
  output logic iack_o,
  input wire logic [7:0] vector_i,
  input wire logic vector_valid_i
);
  // bus idle from time zero
  initial begin
    reg_addr_o = 3'h7;
    reg_wdata_o = 8'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    iack_o = 1'b0;
  end
  // one-cycle write; data inverted after release so stale data never helps
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_wdata_o <= d;
    reg_wr_o <= 1'b1;
    @(posedge core_clk_i);
    reg_wr_o <= 1'b0;
    reg_wdata_o <= ~d;
  endtask : wr
  // one-cycle read; data taken in the following cycle only
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge core_clk_i);
    reg_addr_o <= a;
    reg_rd_o <= 1'b1;
    @(posedge core_clk_i);
    reg_rd_o <= 1'b0;
    #1;
    d = reg_rdata_i;
  endtask : rd
  // vectored acknowledge, answer expected exactly one cycle later
  task automatic ack(output logic [7:0] v, output logic ok);
    @(posedge core_clk_i);
    iack_o <= 1'b1;
    @(posedge core_clk_i);
    iack_o <= 1'b0;
    #1;
    ok = vector_valid_i;
    v = vector_i;
  endtask : ack
endmodule : cpu_model

// ===== bench/gpio_edge_irq_eoi_nesting_tb.sv
// self-checking bench for the nesting and line port block
`timescale 1ns/1ps
module gpio_edge_irq_eoi_nesting_tb;
  import eoi_gpio_pkg::*;
  logic core_clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic [2:0] addr;
  logic [7:0] wdat, rdat, vec, gp_out, gp_oe;
  logic wr, rd, iack, vvld, irq;
  logic [15:0] en = '0, msk = '1, ev = '0, pclr = '0, done = '0;
  logic [3:0] base = 4'h0;
  logic mode = 1'b0;
  logic [7:0] ext = 8'h00;
  logic [15:0] lfsr = 16'h000E;
  // pin level: design drives where enabled, outside world elsewhere
  wire logic [7:0] pin = (gp_oe & gp_out) | (~gp_oe & ext);
  // reference state: pending and in-service, indexed by channel code
  int pend = 0;
  int isr = 0;
  int fail_count = 0;
  int n_checks = 0;
  always #2.5 core_clk_i = ~core_clk_i;
  gpio_edge_irq_eoi_nesting i_dut (.core_clk_i(core_clk_i),
    .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdat),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat),
    .chan_enable_i(en), .chan_mask_i(msk), .vector_base_i(base),
    .eoi_mode_i(mode), .chan_event_i(ev), .pend_clear_i(pclr),
    .service_done_i(done), .iack_i(iack), .vector_o(vec),
    .vector_valid_o(vvld), .irq_o(irq), .gp_line_i(pin),
    .gp_line_o(gp_out), .gp_line_oe_o(gp_oe));
  cpu_model cpu (.core_clk_i(core_clk_i), .reg_addr_o(addr),
    .reg_wdata_o(wdat), .reg_wr_o(wr), .reg_rd_o(rd),
    .reg_rdata_i(rdat), .iack_o(iack), .vector_i(vec),
    .vector_valid_i(vvld));
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt
  // highest eligible code; an in-service bit shuts out itself and below
  function automatic int win();
    for (int k = 15; k >= 0; k--) begin
      if (isr[k]) return -1;
      if (pend[k] && msk[k] && en[k]) return k;
    end
    return -1;
  endfunction : win
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic chk(input string nm, input logic [15:0] e, g);
    n_checks++;
    if (g !== e) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic rdc(input logic [2:0] a, input logic [7:0] e);
    logic [7:0] d;
    cpu.rd(a, d);
    chk("read", e, d);
  endtask : rdc
  // one pulse: 0 event, 1 service done, 2 polled clear
  task automatic pulse(input int s, input int b);
    @(posedge core_clk_i);
    if (s == 0) ev <= 16'h1 << b;
    else if (s == 1) done <= 16'h1 << b;
    else pclr <= 16'h1 << b;
    @(posedge core_clk_i);
    ev <= '0;
    done <= '0;
    pclr <= '0;
    #1;
    if (s == 0) pend |= 1 << b;
    else if (s == 1) isr &= ~(1 << b);
    else pend &= ~(1 << b);
    chk("irq", win() >= 0, irq);
  endtask : pulse
  task automatic ackc();
    int w;
    logic [7:0] v;
    logic ok;
    w = win();
    cpu.ack(v, ok);
    chk("valid", w >= 0, ok);
    if (w >= 0) begin
      chk("vector", {base, w[3:0]}, v);
      pend &= ~(1 << w);
      if (mode) isr |= 1 << w;
    end
    chk("irq", win() >= 0, irq);
  endtask : ackc
  // line edge: bounded wait for the request, then note it pending
  task automatic wline(input int b);
    int i;
    for (i = 0; i < 12 && irq !== 1'b1; i++) begin
      @(posedge core_clk_i);
      #1;
    end
    if (i == 12) begin
      fail_count++;
      $display("CHECK FAILED line irq expected 1 seen 0");
      stop_test();
    end else begin
      pend |= 1 << b;
    end
  endtask : wline
  initial begin
    repeat (10) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    cpu.wr(3'h7, 8'hFF);
    cpu.wr(OFS_PEND_A, 8'hFF);
    for (int a = 0; a < 8; a++) rdc(a[2:0], 8'h00);
    $display("reset and unmapped test done");
    lfsr = nxt(lfsr);
    cpu.wr(OFS_DIRECTION, 8'hF0);
    cpu.wr(OFS_PORT_DATA, lfsr[7:0]);
    ext <= lfsr[15:8];
    repeat (4) @(posedge core_clk_i);
    chk("oe", 8'hF0, gp_oe);
    chk("out", lfsr[7:0], gp_out);
    rdc(OFS_PORT_DATA, (lfsr[7:0] & 8'hF0) | (lfsr[15:8] & 8'h0F));
    cpu.wr(OFS_DIRECTION, 8'h00);
    ext <= 8'h00;
    $display("direction test done");
    // polarity set first, then channels enabled
    cpu.wr(OFS_EDGE_POL, 8'h01);
    repeat (4) @(posedge core_clk_i);
    en <= '1;
    base <= lfsr[3:0];
    ext <= 8'h01;
    wline(0);
    ackc();
    ext <= 8'h03;
    repeat (6) @(posedge core_clk_i);
    #1;
    chk("irq", 16'h0, irq);
    cpu.wr(OFS_EDGE_POL, 8'h03);
    wline(1);
    pulse(0, 4);
    pulse(0, 2);
    ackc();
    ackc();
    rdc(OFS_IN_SVC_B, 8'h00);
    $display("automatic mode test done");
    mode <= 1'b1;
    pulse(0, 5);
    ackc();
    rdc(OFS_IN_SVC_B, isr[7:0]);
    pulse(0, 3);
    pulse(0, 5);
    rdc(OFS_PEND_B, pend[7:0]);
    pulse(0, 9);
    ackc();
    rdc(OFS_IN_SVC_A, isr[15:8]);
    cpu.wr(OFS_IN_SVC_B, 8'hFF);
    cpu.wr(OFS_IN_SVC_A, 8'hFD);
    isr &= 16'hFDFF;
    rdc(OFS_IN_SVC_A, isr[15:8]);
    rdc(OFS_IN_SVC_B, isr[7:0]);
    pulse(1, 5);
    ackc();
    mode <= 1'b0;
    isr = 0;
    rdc(OFS_IN_SVC_B, 8'h00);
    ackc();
    $display("software mode test done");
    msk[6] <= 1'b0;
    pulse(0, 6);
    rdc(OFS_PEND_B, pend[7:0]);
    ackc();
    pulse(2, 6);
    rdc(OFS_PEND_B, 8'h00);
    $display("polled and mask test done");
    stop_test();
  end
endmodule : gpio_edge_irq_eoi_nesting_tb
